/* bench/ser_master.sv */
// Behavioural serial programming master that drives the link pins.
`timescale 1ns/1ps
module ser_master (
    output logic ser_clk,
    output xpt_pkg::serial_pins_s pins,
    input wire logic ser_dout
);
    logic [191:0] cap;
    // The clock stands low and select stays high between frames.
    initial begin
        ser_clk = 1'b0;
        pins = 2'b10;
    end
    // Pulses with select high; the data line toggles so that stray captures show.
    task automatic idle(input int n);
        repeat (n) begin
            #32 ser_clk = 1'b1;
            pins.din = ~pins.din;
            #32 ser_clk = 1'b0;
        end
    endtask
    // One frame; the chained output is recorded at each rise, before the next fall.
    task automatic send(input int n, input logic [191:0] data);
        #16 pins.sel_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            #32 ser_clk = 1'b1;
            cap[i] = ser_dout;
            pins.din = data[i];
            #32 ser_clk = 1'b0;
        end
        // Let the last falling edge take its bit before the lines move.
        #16 pins.din = ~pins.din;
        pins.sel_n = 1'b1;
        idle(1);
    endtask
endmodule

/* bench/tb_crosspoint_serial_programming.sv */
// Self-checking bench for the crosspoint serial programming logic.
`timescale 1ns/1ps
`include "xpt_params.svh"
module tb_crosspoint_serial_programming;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ser_clk;
    logic ser_dout;
    xpt_pkg::serial_pins_s ser_pins;
    xpt_pkg::ctrl_pins_s ctrl_pins = '0;
    xpt_pkg::route_bank_t route;
    xpt_pkg::route_bank_t bank;
    xpt_pkg::route_s rst_e;
    xpt_pkg::route_s bc_e;
    logic [191:0] frame;
    logic [9:0] w;
    int fail_count = 0;
    int check_count = 0;
    int seed = 14;

    // System clock at 10 MHz.
    always #50 sys_clk = ~sys_clk;

    crosspoint_serial_programming dut_u (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .ser_clk(ser_clk),
        .ser_pins(ser_pins),
        .ctrl_pins(ctrl_pins),
        .route(route),
        .ser_dout(ser_dout)
    );
    ser_master master_u (
        .ser_clk(ser_clk),
        .pins(ser_pins),
        .ser_dout(ser_dout)
    );

    // Every output entry set to one value, as the forcing pins and reset leave it.
    function automatic xpt_pkg::route_bank_t fill(input xpt_pkg::route_s e);
        xpt_pkg::route_bank_t b;
        for (int k = 0; k < `XPT_OUTS; k++) b[k] = e;
        return b;
    endfunction
    // An addressed word touches only the entry that its output field names.
    function automatic xpt_pkg::route_bank_t put_word(input xpt_pkg::route_bank_t b,
            input logic [9:0] x);
        b[x[3:0]] = {x[`XPT_WORD_OFF_BIT], x[8:`XPT_WORD_IN_LSB]};
        return b;
    endfunction
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Bounded wait for the matrix, so a copy that never lands counts as a mismatch.
    task automatic settle(input logic [95:0] exp);
        for (int i = 0; i < 10 && route !== exp; i++) @(negedge sys_clk);
        chk(route, exp);
    endtask
    // Gap first, so the freshness toggle from the last frame has crossed over.
    task automatic cfg_pulse();
        repeat (4) @(negedge sys_clk);
        ctrl_pins.cfg = 1'b1;
        repeat (3) @(negedge sys_clk);
        ctrl_pins.cfg = 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence: reset, serial chain frame, forcing pins, addressed words.
    initial begin
        rst_e = '{off: `XPT_RST_OFF, in_addr: `XPT_RST_ADDR};
        bc_e = '{off: `XPT_BROADCAST_ALL_PIN_OFF, in_addr: `XPT_BROADCAST_ALL_PIN_ADDR};
        repeat (4) @(negedge sys_clk);
        master_u.idle(6);
        repeat (9) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk(route, fill(rst_e));
        master_u.idle(4);
        for (int k = 0; k < 6; k++) frame[32*k +: 32] = $random(seed);
        master_u.send(192, frame);
        chk(route, fill(rst_e));
        chk(master_u.cap[95:0], fill(rst_e));
        chk(master_u.cap[191:96], frame[95:0]);
        cfg_pulse();
        settle(frame[191:96]);
        ctrl_pins.broadcast_all_pin = 1'b1;
        settle(fill(bc_e));
        ctrl_pins.clear_all = 1'b1;
        settle(fill(rst_e));
        ctrl_pins.clear_all = 1'b0;
        ctrl_pins.broadcast_all_pin = 1'b0;
        cfg_pulse();
        repeat (8) @(negedge sys_clk);
        chk(route, fill(rst_e));
        ctrl_pins.mode = 1'b1;
        master_u.idle(3);
        bank = frame[191:96];
        for (int k = 0; k < 5; k++) begin
            w = 10'($random(seed));
            if (k == 0) w[3:0] = 4'hF;
            if (k == 1) w[3:0] = 4'h0;
            master_u.send(10, {182'h0, w});
            bank = put_word(bank, w);
        end
        master_u.idle(5);
        chk(route, fill(rst_e));
        cfg_pulse();
        settle(bank);
        // Three-wire hookup: configure follows select up after one more word.
        w = 10'($random(seed));
        master_u.send(10, {182'h0, w});
        bank = put_word(bank, w);
        @(negedge sys_clk);
        ctrl_pins.cfg = 1'b1;
        settle(bank);
        ctrl_pins.cfg = 1'b0;
        final_report();
    end
endmodule

/* rtl/crosspoint_serial_programming.sv */
// Serial programming logic: staging shift register and active routing bank.
//
// Contract
// - One active routing entry per output drives the matrix; serial side cannot reach it.
// - A staging bank of the same shape is loaded only through serial input.
// - Select is active low; while high, data and clock are ignored.
// - After select falls, arm on first rising clock; first bit on next falling.
// - Every serial bit is sampled on a falling clock edge.
// - Staged data reaches active entries only on a configure pulse, either format.
// - Configure and mode work independently of select.
// - Configure pulses without new staged data leave the routing unchanged.
// - Mode high: addressed words update only the named output's staging entry.
// - Mode low: a 96-bit stream sets the staging entries of all 16 outputs.
// - The first bit shifted in is frame bit 0.
// - With select low, mode low and clock running, the shift register keeps shifting out.
// - Serial entry: 5-bit input address LSB first, then off bit, output 0 first.
// - Addressed word: 4-bit output, 5-bit input, off bit, each LSB first.
// - Serial data out feeds a chained device; 96 clocks pass, 192 fill both.
// - Clear-all forces address 0 off; broadcast forces all on from input 0.
`timescale 1ns/1ps
`include "xpt_params.svh"
module crosspoint_serial_programming (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ser_clk,
    input wire xpt_pkg::serial_pins_s ser_pins,
    input wire xpt_pkg::ctrl_pins_s ctrl_pins,
    output xpt_pkg::route_bank_t route,
    output logic ser_dout
);
    // Link-domain state, all on the serial clock.
    xpt_pkg::link_state_e link_state;
    xpt_pkg::link_state_e next_link_state;
    xpt_pkg::route_bank_t stage;
    xpt_pkg::route_bank_t next_stage;
    logic [`XPT_WORD_W-1:0] word_sr;
    logic [`XPT_WORD_W-1:0] next_word_sr;
    logic [3:0] word_cnt;
    logic [3:0] next_word_cnt;
    logic fresh_tgl;
    logic next_fresh_tgl;
    logic link_rst;
    logic link_mode;
    logic capture;
    logic [`XPT_WORD_W-1:0] word_full;
    logic [`XPT_FRAME_W-1:0] stage_bits;
    logic ack_l;

    // System-domain state.
    logic [3:0] ctrl_s;
    logic cfg_s;
    logic clear_s;
    logic broadcast_all_pin_s;
    logic tgl_s;
    logic cfg_prev;
    logic next_cfg_prev;
    logic tgl_seen;
    logic next_tgl_seen;
    xpt_pkg::route_bank_t active;
    xpt_pkg::route_bank_t next_active;
    logic cfg_rise;
    logic pending;

    // Builds one routing entry.
    function automatic xpt_pkg::route_s make_entry(
        input logic [`XPT_IN_AW-1:0] addr,
        input logic off
    );
        xpt_pkg::route_s e;
        e.in_addr = addr;
        e.off = off;
        return e;
    endfunction

    // The serial clock may stop, so reset reaches it through its own synchroniser.
    // The copy acknowledge from the system side comes back the same way.
    sync_bits #(.W(3)) u_link_sync (
        .clk(ser_clk),
        .rst(1'b0),
        .d({sys_rst, ctrl_pins.mode, tgl_seen}),
        .q({link_rst, link_mode, ack_l})
    );

    // Arming happens on rising edges only; select high drops back to idle.
    always_comb begin
        next_link_state = link_state;
        if (link_rst || ser_pins.sel_n) begin
            next_link_state = xpt_pkg::LINK_IDLE;
        end else begin
            next_link_state = xpt_pkg::LINK_ARMED;
        end
    end

    // Rising-edge register of the arming state.
    always_ff @(posedge ser_clk) begin
        link_state <= next_link_state;
    end

    // A bit is taken only while armed and selected.
    assign capture = (link_state == xpt_pkg::LINK_ARMED) && !ser_pins.sel_n;
    assign word_full = {ser_pins.din, word_sr[`XPT_WORD_W-1:1]};
    assign stage_bits = stage;

    // Falling-edge shift logic for both formats.
    always_comb begin
        next_stage = stage;
        next_word_sr = word_sr;
        next_word_cnt = word_cnt;
        next_fresh_tgl = fresh_tgl;
        if (link_rst) begin
            next_stage = {`XPT_OUTS{make_entry(`XPT_RST_ADDR, `XPT_RST_OFF)}};
            next_word_sr = '0;
            next_word_cnt = 4'h0;
            next_fresh_tgl = 1'b0;
        end else if (!capture) begin
            // A new select frame always restarts the addressed word.
            next_word_cnt = 4'h0;
        end else if (!link_mode) begin
            // New bits enter at the top, so frame bit 0 lands in entry 0.
            next_stage = {ser_pins.din, stage_bits[`XPT_FRAME_W-1:1]};
            // One notice per batch of new data; a toggle per bit would cancel itself
            // on any even bit count. A frame must last two clocks so that a returned
            // acknowledge has caught up before its last bit.
            if (fresh_tgl == ack_l) begin
                next_fresh_tgl = !fresh_tgl;
            end
        end else begin
            next_word_sr = word_full;
            if (word_cnt == `XPT_WORD_LAST) begin
                next_word_cnt = 4'h0;
                next_stage[word_full[`XPT_WORD_OUT_LSB +: `XPT_OUT_AW]] = make_entry(
                    word_full[`XPT_WORD_IN_LSB +: `XPT_IN_AW],
                    word_full[`XPT_WORD_OFF_BIT]);
                if (fresh_tgl == ack_l) begin
                    next_fresh_tgl = !fresh_tgl;
                end
            end else begin
                next_word_cnt = word_cnt + 4'h1;
            end
        end
    end

    // Every serial input bit is taken on the falling edge.
    always_ff @(negedge ser_clk) begin
        stage <= next_stage;
        word_sr <= next_word_sr;
        word_cnt <= next_word_cnt;
        fresh_tgl <= next_fresh_tgl;
    end

    // The oldest staged bit is the chain output, so a chained device
    // sees the new frame only after this one is full.
    assign ser_dout = stage[0].in_addr[0];

    // Configure, clear, broadcast and the freshness toggle enter the system domain.
    sync_bits #(.W(4)) u_sys_sync (
        .clk(sys_clk),
        .rst(sys_rst),
        .d({ctrl_pins.cfg, ctrl_pins.clear_all, ctrl_pins.broadcast_all_pin, fresh_tgl}),
        .q(ctrl_s)
    );
    assign cfg_s = ctrl_s[3];
    assign clear_s = ctrl_s[2];
    assign broadcast_all_pin_s = ctrl_s[1];
    assign tgl_s = ctrl_s[0];

    // Configure works regardless of select, which also permits a three-wire hookup.
    assign cfg_rise = cfg_s && !cfg_prev;
    // A notice that differs from the last acknowledged one means the bank holds
    // unapplied data; it is quiet by then because configure waits for the shift.
    assign pending = tgl_s != tgl_seen;

    // Active bank update; clear wins over broadcast, both over configure.
    always_comb begin
        next_cfg_prev = cfg_s;
        next_tgl_seen = tgl_seen;
        next_active = active;
        if (sys_rst) begin
            next_cfg_prev = 1'b0;
            next_tgl_seen = 1'b0;
            next_active = {`XPT_OUTS{make_entry(`XPT_RST_ADDR, `XPT_RST_OFF)}};
        end else if (clear_s) begin
            next_active = {`XPT_OUTS{make_entry(`XPT_RST_ADDR, `XPT_RST_OFF)}};
        end else if (broadcast_all_pin_s) begin
            next_active = {`XPT_OUTS{make_entry(`XPT_BROADCAST_ALL_PIN_ADDR, `XPT_BROADCAST_ALL_PIN_OFF)}};
        end else if (cfg_rise && pending) begin
            // The whole bank moves at once, so the matrix never shows a mix.
            next_active = stage;
            next_tgl_seen = tgl_s;
        end
    end

    // System-domain registers; the matrix is driven only from here.
    always_ff @(posedge sys_clk) begin
        cfg_prev <= next_cfg_prev;
        tgl_seen <= next_tgl_seen;
        active <= next_active;
        route <= next_active;
    end

    // A configure edge with clear and broadcast both low.
    sequence s_cfg_plain;
        cfg_rise && !clear_s && !broadcast_all_pin_s;
    endsequence

    // The same edge while the staging bank holds fresh data.
    sequence s_cfg_fresh;
        s_cfg_plain ##0 pending;
    endsequence

    a_cfg_copies_stage: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_cfg_fresh |=> (active == $past(stage)) ##1 !pending)
        else $error("configure did not copy the staging bank");

    a_stale_cfg_hold: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_cfg_plain ##0 !pending |=> $stable(active))
        else $error("configure without new data changed routing");

    a_no_cfg_hold: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !cfg_rise && !clear_s && !broadcast_all_pin_s |=> $stable(active))
        else $error("routing changed without configure");

    a_clear_all_off: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        clear_s |=> active == {`XPT_OUTS{make_entry(`XPT_RST_ADDR, `XPT_RST_OFF)}})
        else $error("clear-all did not turn every output off");

    a_broadcast_all_pin_all_on: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !clear_s && broadcast_all_pin_s |=> active == {`XPT_OUTS{make_entry(`XPT_BROADCAST_ALL_PIN_ADDR, `XPT_BROADCAST_ALL_PIN_OFF)}})
        else $error("broadcast did not route input 0 to all outputs");

    a_route_source: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $changed(route) |-> $past(clear_s || broadcast_all_pin_s || (cfg_rise && pending)))
        else $error("matrix changed without configure, clear or broadcast");

    a_select_high_idle: assert property (
        @(posedge ser_clk) disable iff (link_rst)
        ser_pins.sel_n |=> link_state == xpt_pkg::LINK_IDLE)
        else $error("link stayed armed with select high");

    a_idle_stage_hold: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        !capture |=> $stable(stage) && word_cnt == 4'h0)
        else $error("staging bank moved while not selected");

    a_serial_shift_in: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        capture && !link_mode |=> stage[`XPT_OUTS-1].off == $past(ser_pins.din)
            && ser_dout == $past(stage[0].in_addr[1]))
        else $error("serial bit not shifted in at the top");

    a_word_writes_entry: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        capture && link_mode && word_cnt == `XPT_WORD_LAST
            |=> stage[$past(word_full[`XPT_WORD_OUT_LSB +: `XPT_OUT_AW])]
                == $past(make_entry(word_full[`XPT_WORD_IN_LSB +: `XPT_IN_AW],
                    word_full[`XPT_WORD_OFF_BIT])))
        else $error("addressed word did not reach its entry");

    a_word_partial_hold: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        capture && link_mode && word_cnt != `XPT_WORD_LAST |=> $stable(stage))
        else $error("partial addressed word changed staging");

    // One serial-format bit taken at a falling edge.
    sequence s_serial_bit;
        capture && !link_mode;
    endsequence

    // An addressed bit that does not yet finish its word.
    sequence s_word_step;
        capture && link_mode && word_cnt != `XPT_WORD_LAST;
    endsequence

    // The tenth bit of an addressed word.
    sequence s_word_end;
        capture && link_mode && word_cnt == `XPT_WORD_LAST;
    endsequence

    // Selected at a rising edge means armed for the falling edge that follows.
    a_arm_on_rise: assert property (
        @(posedge ser_clk) disable iff (link_rst)
        !ser_pins.sel_n |=> link_state == xpt_pkg::LINK_ARMED)
        else $error("link did not arm on a rising edge with select low");

    // Nothing is taken on a falling edge before the link has armed.
    a_unarmed_hold: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        link_state == xpt_pkg::LINK_IDLE |=> $stable(stage))
        else $error("staging moved before the link armed");

    // The first serial bit of a batch raises the freshness notice.
    a_fresh_on_shift: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        s_serial_bit ##0 fresh_tgl == ack_l |=> fresh_tgl != $past(fresh_tgl))
        else $error("serial data did not raise the freshness notice");

    // A finished addressed word raises the notice as well.
    a_fresh_on_word: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        s_word_end ##0 fresh_tgl == ack_l |=> fresh_tgl != $past(fresh_tgl))
        else $error("addressed word did not raise the freshness notice");

    // While a notice is outstanding, more data must not flip it back.
    a_fresh_once: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        fresh_tgl != ack_l |=> $stable(fresh_tgl))
        else $error("freshness notice flipped twice");

    // Without a captured bit the notice stays where it is.
    a_idle_fresh_hold: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        !capture |=> $stable(fresh_tgl))
        else $error("freshness notice moved without data");

    // Each addressed bit but the last advances the word count by one.
    a_word_count_step: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        s_word_step |=> word_cnt == $past(word_cnt) + 4'h1)
        else $error("addressed word count did not advance");

    // The tenth bit closes the word and the count starts again.
    a_word_count_wrap: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        s_word_end |=> word_cnt == 4'h0)
        else $error("addressed word count did not restart");

    // Serial format leaves the word count alone.
    a_serial_count_hold: assert property (
        @(negedge ser_clk) disable iff (link_rst)
        s_serial_bit |=> $stable(word_cnt))
        else $error("serial bit moved the word count");

    // Link reset puts every staging entry at input 0, off.
    a_link_reset_stage: assert property (
        @(negedge ser_clk)
        link_rst |=> stage == {`XPT_OUTS{make_entry(`XPT_RST_ADDR, `XPT_RST_OFF)}})
        else $error("link reset did not clear the staging bank");

    // System reset turns every matrix output off.
    a_reset_route_off: assert property (
        @(posedge sys_clk)
        sys_rst |=> route == {`XPT_OUTS{make_entry(`XPT_RST_ADDR, `XPT_RST_OFF)}})
        else $error("reset did not turn the matrix off");
endmodule

/* rtl/sync_bits.sv */
// Two flip-flop synchroniser for a group of level signals.
`timescale 1ns/1ps
module sync_bits #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // The first stage feeds only the second stage.
    always_comb begin
        next_meta = rst ? '0 : d;
        next_q = rst ? '0 : meta;
    end

    // Both stages register on every rising edge.
    always_ff @(posedge clk) begin
        meta <= next_meta;
        q <= next_q;
    end
endmodule

/* rtl/xpt_params.svh */
// Constants for the crosspoint serial programming logic.
`ifndef XPT_PARAMS_SVH
`define XPT_PARAMS_SVH
`define XPT_OUTS 16
`define XPT_IN_AW 5
`define XPT_OUT_AW 4
`define XPT_ENTRY_W 6
`define XPT_FRAME_W 96
`define XPT_WORD_W 10
`define XPT_WORD_LAST 4'h9
`define XPT_WORD_OUT_LSB 0
`define XPT_WORD_IN_LSB 4
`define XPT_WORD_OFF_BIT 9
`define XPT_RST_ADDR 5'h00
`define XPT_RST_OFF 1'b1
`define XPT_BROADCAST_ALL_PIN_ADDR 5'h00
`define XPT_BROADCAST_ALL_PIN_OFF 1'b0
`define XPT_SYNC_STAGES 2
`endif

/* rtl/xpt_pkg.sv */
// Types shared by the crosspoint serial programming logic.
`include "xpt_params.svh"
package xpt_pkg;
    typedef struct packed {
        logic off;
        logic [`XPT_IN_AW-1:0] in_addr;
    } route_s;
    typedef route_s [`XPT_OUTS-1:0] route_bank_t;
    typedef struct packed {
        logic sel_n;
        logic din;
    } serial_pins_s;
    typedef struct packed {
        logic cfg;
        logic mode;
        logic clear_all;
        logic broadcast_all_pin;
    } ctrl_pins_s;
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_ARMED = 2'b01
    } link_state_e;
endpackage
